// file: tcp_pkg.sv
package tcp_pkg;

  // ----------------------------------------------------------------
  // register map (word aligned, low byte lane carries the data)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_COUNT_LOW = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_COUNT_HIGH_BUF = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_INT_CTRL = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_TIMER_CTRL = 4'hC;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int TC_RUN_BIT = 7;
  localparam int TC_WIDTH_BIT = 6;
  localparam int TC_SRC_BIT = 5;
  localparam int TC_EDGE_BIT = 4;
  localparam int TC_BYPASS_BIT = 3;
  localparam int TC_RATIO_LSB = 0;
  localparam int IC_IRQ_EN_BIT = 5;
  localparam int IC_FLAG_BIT = 2;

  // ----------------------------------------------------------------
  // reset values and timing counts
  // ----------------------------------------------------------------
  localparam logic [7:0] TIMER_CTRL_RESET = 8'hFF;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam int INSTR_DIV = 4;
  localparam logic [1:0] INHIBIT_CYCLES = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // low n+1 bits set: prescaler terminal pattern for ratio code n
  function automatic logic [7:0] tcp_psc_mask(input logic [2:0] ratio);
    tcp_psc_mask = 8'hFF >> (3'h7 - ratio);
  endfunction : tcp_psc_mask

endpackage : tcp_pkg

// file: tcp_psc_if.sv
interface tcp_psc_if;
  logic src_event;
  logic clear;
  logic bypass;
  logic [2:0] ratio;
  logic tick;

  modport core (output src_event, output clear, output bypass, output ratio, input tick);
  modport psc (input src_event, input clear, input bypass, input ratio, output tick);
endinterface : tcp_psc_if

// file: tcp_prescaler.sv
module tcp_prescaler (
  input wire logic core_clk_i,
  input wire logic rst_i,
  tcp_psc_if.psc psc_if
);
  import tcp_pkg::*;

  logic [7:0] psc_cnt;
  logic [7:0] mask;

  // ----------------------------------------------------------------
  // hidden 8-bit divider, never visible to software
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i || psc_if.clear) begin
      psc_cnt <= 8'h00;
    end else if (psc_if.src_event) begin
      psc_cnt <= psc_cnt + 8'h01;
    end
  end

  // ratio and bypass are read live, so reassignment needs no stop
  assign mask = tcp_psc_mask(psc_if.ratio);
  assign psc_if.tick = psc_if.src_event && !psc_if.clear &&
                       (psc_if.bypass || ((psc_cnt & mask) == mask));

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  a_psc_clear_zero: assert property (psc_if.clear |=> psc_cnt == 8'h00)
    else $error("prescaler not cleared by count write");
  a_psc_ratio_tick: assert property (
    (psc_if.tick && !psc_if.bypass) |-> ((psc_cnt & mask) == mask))
    else $error("prescaler tick at wrong count");

endmodule : tcp_prescaler

// file: tcp_timer_counter.sv
// What this block does
// - source select 0: count instruction cycles or prescaler
// - count write blocks counting two instruction cycles
// - source select 1: pin edges, edge bit picks
// - pin synchronised before use, adds latency
// - 16-bit low read copies upper into buffer
// - upper byte reached only through buffer
// - low write loads upper from buffer together
// - reset: running, 8-bit, pin, prescaler bypassed
// - prescaler is hidden 8-bit counter
// - bypass 0: prescaler ratios 1:2 to 1:256
// - count write clears prescaler when assigned, keeps assignment
// - assignment may change while counter runs
// - flag set on FFh or FFFFh rollover
// - request raised only while enable set
// - sleep stops the counter entirely
// - run bit starts and stops, count kept
// - width bit 1 is 8-bit, 0 16-bit
// - bypass 1: one step per source event
module tcp_timer_counter (
  input wire logic core_clk_i,
  input wire logic rst_i,
  // axi4-lite write address
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [tcp_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  // axi4-lite write data
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  // axi4-lite write response
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  // axi4-lite read address
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [tcp_pkg::ADDR_W-1:0] s_axi_araddr_i,
  // axi4-lite read data
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  // device side
  input wire logic ext_count_pin_i,
  input wire logic sleep_i,
  output logic overflow_irq_o
);
  import tcp_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] timer_control;
  logic [7:0] count_lo;
  logic [7:0] count_hi;
  logic [7:0] count_high_buffer;
  logic overflow_flag;
  logic overflow_irq_enable;
  logic [1:0] inhibit_cnt;
  logic [$clog2(INSTR_DIV)-1:0] div_cnt;
  logic instr_en;
  logic ext_sync1;
  logic ext_sync2;
  logic ext_prev;
  logic edge_rise;
  logic edge_fall;
  logic cnt_step;
  logic ovf_event;

  // bus bookkeeping
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic rd_fire;
  logic wr_count_lo;
  logic wr_high_buf;
  logic wr_int_ctrl;
  logic wr_timer_ctrl;
  logic rd_count_lo;

  // control field views
  logic run_control;
  logic width_select;
  logic source_select;
  logic edge_select;
  logic prescaler_bypass;
  logic [2:0] prescale_ratio;

  tcp_psc_if psc_if ();

  assign run_control = timer_control[TC_RUN_BIT];
  assign width_select = timer_control[TC_WIDTH_BIT];
  assign source_select = timer_control[TC_SRC_BIT];
  assign edge_select = timer_control[TC_EDGE_BIT];
  assign prescaler_bypass = timer_control[TC_BYPASS_BIT];
  assign prescale_ratio = timer_control[TC_RATIO_LSB +: 3];

  // word decode shared by both channels; byte bits are ignored
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] off);
    reg_hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
  endfunction : reg_hit

  function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
    reg_mapped = reg_hit(a, ADDR_COUNT_LOW) || reg_hit(a, ADDR_COUNT_HIGH_BUF) ||
                 reg_hit(a, ADDR_INT_CTRL) || reg_hit(a, ADDR_TIMER_CTRL);
  endfunction : reg_mapped

  // ----------------------------------------------------------------
  // write channels: address and data taken in either order
  // ----------------------------------------------------------------
  assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
  assign s_axi_wready_o = !w_held && !s_axi_bvalid_o;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid_o;

  // address holding register
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr_i;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  // data holding register
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata_i;
      w_strb <= s_axi_wstrb_i;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  // response one cycle after both halves are in; unmapped gets slverr
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= reg_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // only byte lane 0 carries register bits
  assign wr_count_lo = wr_fire && w_strb[0] && reg_hit(aw_addr, ADDR_COUNT_LOW);
  assign wr_high_buf = wr_fire && w_strb[0] && reg_hit(aw_addr, ADDR_COUNT_HIGH_BUF);
  assign wr_int_ctrl = wr_fire && w_strb[0] && reg_hit(aw_addr, ADDR_INT_CTRL);
  assign wr_timer_ctrl = wr_fire && w_strb[0] && reg_hit(aw_addr, ADDR_TIMER_CTRL);

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  assign s_axi_arready_o = !s_axi_rvalid_o;
  assign rd_fire = s_axi_arvalid_i && s_axi_arready_o;
  assign rd_count_lo = rd_fire && reg_hit(s_axi_araddr_i, ADDR_COUNT_LOW);

  // the true upper byte is never muxed out, only its buffer
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= '0;
      s_axi_rresp_o <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o <= reg_mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
      s_axi_rdata_o <= 32'h0000_0000;
      if (reg_hit(s_axi_araddr_i, ADDR_COUNT_LOW)) begin
        s_axi_rdata_o[7:0] <= count_lo;
      end else if (reg_hit(s_axi_araddr_i, ADDR_COUNT_HIGH_BUF)) begin
        s_axi_rdata_o[7:0] <= count_high_buffer;
      end else if (reg_hit(s_axi_araddr_i, ADDR_INT_CTRL)) begin
        s_axi_rdata_o[IC_IRQ_EN_BIT] <= overflow_irq_enable;
        s_axi_rdata_o[IC_FLAG_BIT] <= overflow_flag;
      end else if (reg_hit(s_axi_araddr_i, ADDR_TIMER_CTRL)) begin
        s_axi_rdata_o[7:0] <= timer_control;
      end
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      timer_control <= TIMER_CTRL_RESET;
    end else if (wr_timer_ctrl) begin
      timer_control <= w_data[7:0];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      overflow_irq_enable <= 1'b0;
    end else if (wr_int_ctrl) begin
      overflow_irq_enable <= w_data[IC_IRQ_EN_BIT];
    end
  end

  // a rollover in the clearing cycle wins, so no event is lost
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      overflow_flag <= 1'b0;
    end else if (ovf_event) begin
      overflow_flag <= 1'b1;
    end else if (wr_int_ctrl) begin
      overflow_flag <= w_data[IC_FLAG_BIT];
    end
  end

  // enable only masks the request; the flag keeps setting
  assign overflow_irq_o = overflow_flag && overflow_irq_enable;

  // ----------------------------------------------------------------
  // instruction-cycle enable and pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      div_cnt <= '0;
    end else if (div_cnt == ($clog2(INSTR_DIV))'(INSTR_DIV - 1)) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end
  assign instr_en = (div_cnt == ($clog2(INSTR_DIV))'(INSTR_DIV - 1));

  // two flops against metastability, a third for edge history
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ext_sync1 <= 1'b0;
      ext_sync2 <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      ext_sync1 <= ext_count_pin_i;
      ext_sync2 <= ext_sync1;
      ext_prev <= ext_sync2;
    end
  end
  assign edge_rise = ext_sync2 && !ext_prev;
  assign edge_fall = !ext_sync2 && ext_prev;

  // ----------------------------------------------------------------
  // source selection and prescaler hookup
  // ----------------------------------------------------------------
  assign psc_if.src_event = run_control && !sleep_i &&
                            (source_select ? (edge_select ? edge_fall : edge_rise)
                                           : instr_en);
  assign psc_if.clear = wr_count_lo && !prescaler_bypass;
  assign psc_if.bypass = prescaler_bypass;
  assign psc_if.ratio = prescale_ratio;

  tcp_prescaler u_prescaler (
    .core_clk_i (core_clk_i),
    .rst_i (rst_i),
    .psc_if (psc_if.psc)
  );

  // write inhibit measured in instruction cycles, not core clocks
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      inhibit_cnt <= 2'h0;
    end else if (wr_count_lo) begin
      inhibit_cnt <= INHIBIT_CYCLES;
    end else if (instr_en && inhibit_cnt != 2'h0) begin
      inhibit_cnt <= inhibit_cnt - 2'h1;
    end
  end

  assign cnt_step = psc_if.tick && inhibit_cnt == 2'h0 && !wr_count_lo;
  assign ovf_event = cnt_step && count_lo == 8'hFF &&
                     (width_select || count_hi == 8'hFF);

  // ----------------------------------------------------------------
  // count and high-byte buffer
  // ----------------------------------------------------------------
  // software write beats an increment in the same cycle
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      count_lo <= COUNT_RESET;
      count_hi <= COUNT_RESET;
    end else if (wr_count_lo) begin
      count_lo <= w_data[7:0];
      count_hi <= count_high_buffer;
    end else if (cnt_step) begin
      if (width_select) begin
        count_lo <= count_lo + 8'h01;
      end else begin
        {count_hi, count_lo} <= {count_hi, count_lo} + 16'h0001;
      end
    end
  end

  // buffer write wins over a low-byte read copy in the same cycle
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      count_high_buffer <= COUNT_RESET;
    end else if (wr_high_buf) begin
      count_high_buffer <= w_data[7:0];
    end else if (rd_count_lo && !width_select) begin
      count_high_buffer <= count_hi;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  a_write_inhibit_span: assert property (wr_count_lo |=> !cnt_step [*4])
    else $error("counting resumed too early after count write");
  a_step8_low_only: assert property (
    (cnt_step && width_select) |=> count_lo == $past(count_lo) + 8'h01)
    else $error("8-bit step did not advance low byte");
  a_hold_upper8: assert property (
    (width_select && !wr_count_lo) |=> $stable(count_hi))
    else $error("upper byte moved in 8-bit width");
  a_ovf_sets_flag: assert property (ovf_event |=> overflow_flag)
    else $error("rollover did not set flag");
  a_irq_masked: assert property (!overflow_irq_enable |-> !overflow_irq_o)
    else $error("request raised while masked");
  a_low_read_copy: assert property (
    (rd_count_lo && !width_select && !wr_high_buf) |=>
      count_high_buffer == $past(count_hi))
    else $error("buffer not loaded on low read");
  a_buf_write_quiet: assert property (
    (wr_high_buf && !cnt_step) |=> $stable(count_hi) && $stable(count_lo))
    else $error("buffer write changed count");
  a_stopped_holds: assert property (
    (!run_control && !wr_count_lo) |=> $stable(count_lo) && $stable(count_hi))
    else $error("count moved while stopped");
  a_sleep_no_step: assert property (sleep_i |-> !cnt_step)
    else $error("count stepped during sleep");
  a_timer_needs_tick: assert property (
    (cnt_step && !source_select) |-> instr_en)
    else $error("timer mode step without instruction cycle");

endmodule : tcp_timer_counter

// file: tcp_pulse_src.sv
module tcp_pulse_src (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic idle_hi_i,
  input wire logic start_i,
  input wire logic [8:0] count_i,
  input wire logic [3:0] half_i,
  output logic pin_o,
  output logic busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] edges_left;
  logic [3:0] dwell;
  logic away;

  // a pulse leaves the idle level and comes back; each level lasts half_i
  // cycles (two or more) so the far side's synchroniser never misses one
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      edges_left <= 10'h000;
      dwell <= 4'h0;
      away <= 1'h0;
    end else if (start_i) begin
      edges_left <= {count_i, 1'h0};
      dwell <= 4'h0;
    end else if (dwell != 4'h0) begin
      dwell <= dwell - 4'h1;
    end else if (edges_left != 10'h000) begin
      away <= ~away;
      edges_left <= edges_left - 10'h001;
      dwell <= half_i - 4'h1;
    end
  end

  // busy spans the last level too, so back-to-back trains keep their spacing
  assign busy_o = (edges_left != 10'h000) || (dwell != 4'h0);
  assign pin_o = idle_hi_i ^ away;
endmodule : tcp_pulse_src

// file: tcp_timer_counter_test.sv
module tcp_timer_counter_test;
  timeunit 1ns;
  timeprecision 1ps;
  import tcp_pkg::*;
  localparam logic [3:0] LO = ADDR_COUNT_LOW;
  localparam logic [3:0] HB = ADDR_COUNT_HIGH_BUF;
  localparam logic [3:0] IC = ADDR_INT_CTRL;
  localparam logic [3:0] TC = ADDR_TIMER_CTRL;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic awv = 1'h0;
  logic awr;
  logic [3:0] awa = 4'h0;
  logic wv = 1'h0;
  logic wrdy;
  logic [31:0] wd = 32'h0;
  logic bv;
  logic br = 1'h0;
  logic [1:0] bresp;
  logic arv = 1'h0;
  logic arr;
  logic [3:0] ara = 4'h0;
  logic rv;
  logic rr = 1'h0;
  logic [31:0] rdat;
  logic [1:0] rresp;
  logic pin;
  logic slp = 1'h0;
  logic irq;
  logic idle_hi = 1'h0;
  logic go = 1'h0;
  logic [8:0] pn = 9'h000;
  logic busy;
  logic [7:0] v;
  int error_cnt = 0;
  int n_checks = 0;

  always #2.5 clk = ~clk;

  tcp_timer_counter dut (.core_clk_i(clk), .rst_i(rst), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_awaddr_i(awa), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wrdy), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(br), .s_axi_bresp_o(bresp),
    .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_araddr_i(ara),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rr), .s_axi_rdata_o(rdat),
    .s_axi_rresp_o(rresp), .ext_count_pin_i(pin), .sleep_i(slp), .overflow_irq_o(irq));

  tcp_pulse_src src (.core_clk_i(clk), .rst_i(rst), .idle_hi_i(idle_hi),
    .start_i(go), .count_i(pn), .half_i(4'h2), .pin_o(pin), .busy_o(busy));

  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic give_verdict();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  // one edge of a bounded wait; running out counts as a mismatch
  task automatic tick(inout int k);
    @(posedge clk);
    k++;
    if (k > 6000) begin
      error_cnt++;
      give_verdict();
    end
  endtask : tick

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // address and data go out together, each dropped once taken
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk);
    awa <= a;
    wd <= {24'h000000, d};
    awv <= 1'h1;
    wv <= 1'h1;
    br <= 1'h1;
    do begin
      tick(k);
      if (awv && awr) awv <= 1'h0;
      if (wv && wrdy) wv <= 1'h0;
    end while (!bv);
    chk("write response", {6'h00, bresp}, {6'h00, RESP_OKAY});
    br <= 1'h0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk);
    ara <= a;
    arv <= 1'h1;
    rr <= 1'h1;
    do begin
      tick(k);
      if (arv && arr) arv <= 1'h0;
    end while (!rv);
    chk("read response", {6'h00, rresp}, {6'h00, RESP_OKAY});
    rr <= 1'h0;
    d = rdat[7:0];
  endtask : rd

  task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk($sformatf("register %h", a), d, e);
  endtask : rdchk

  task automatic pulses(input logic [8:0] n);
    int k;
    k = 0;
    @(posedge clk);
    pn <= n;
    go <= 1'h1;
    @(posedge clk);
    go <= 1'h0;
    do tick(k); while (busy);
    cyc(10);
  endtask : pulses

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_pin();
    idle_hi <= 1'h1;
    cyc(10);
    rdchk(LO, 8'h00);
    idle_hi <= 1'h0;
    cyc(10);
    rdchk(LO, 8'h01);
    wr(TC, 8'hE8);
    idle_hi <= 1'h1;
    cyc(10);
    rdchk(LO, 8'h02);
    idle_hi <= 1'h0;
    cyc(10);
    rdchk(LO, 8'h02);
    pulses(9'h005);
    rdchk(LO, 8'h07);
  endtask : t_pin

  task automatic t_psc();
    for (int n = 0; n < 8; n++) begin
      wr(TC, 8'hE0 | 8'(n));
      wr(LO, 8'h00);
      cyc(12);
      pulses(9'((2 << n) - 1));
      rdchk(LO, 8'h00);
      pulses(9'h001);
      rdchk(LO, 8'h01);
    end
    // a count write seven events into a 1:8 period drops the partial count
    wr(TC, 8'hE2);
    pulses(9'h007);
    wr(LO, 8'h10);
    cyc(12);
    pulses(9'h007);
    rdchk(LO, 8'h10);
    rdchk(TC, 8'hE2);
    wr(TC, 8'hEA);
    pulses(9'h001);
    rdchk(LO, 8'h11);
  endtask : t_psc

  task automatic t_run();
    wr(TC, 8'hC8);
    wr(LO, 8'h40);
    rdchk(LO, 8'h40);
    cyc(40);
    rd(LO, v);
    // 45 edges hold 11 or 12 instruction cycles, two of them swallowed
    chk("timer advance", 8'(v > 8'h48 && v < 8'h4B), 8'h01);
    // timer through a 1:2 prescaler: the first run event lands in the inhibit
    wr(TC, 8'h40);
    wr(LO, 8'h00);
    wr(TC, 8'hC0);
    cyc(40);
    rdchk(LO, 8'h05);
    wr(TC, 8'h48);
    rd(LO, v);
    cyc(40);
    rdchk(LO, v);
    wr(TC, 8'hC8);
    slp <= 1'h1;
    rd(LO, v);
    cyc(40);
    rdchk(LO, v);
    slp <= 1'h0;
  endtask : t_run

  task automatic t_ovf();
    wr(TC, 8'h48);
    wr(IC, 8'h00);
    wr(LO, 8'hFC);
    wr(TC, 8'hC8);
    cyc(40);
    wr(TC, 8'h48);
    rdchk(IC, 8'h04);
    chk("irq masked", 8'(irq), 8'h00);
    // handler order: clear the flag first, only then enable
    wr(IC, 8'h00);
    rdchk(IC, 8'h00);
    wr(IC, 8'h20);
    chk("irq enabled idle", 8'(irq), 8'h00);
    wr(LO, 8'hFC);
    wr(TC, 8'hC8);
    cyc(40);
    wr(TC, 8'h48);
    chk("irq enabled", 8'(irq), 8'h01);
    wr(IC, 8'h20);
    chk("irq after clear", 8'(irq), 8'h00);
    rdchk(IC, 8'h20);
  endtask : t_ovf

  // upper byte is seen only through the buffer; start near a carry
  task automatic t_wide(input logic [7:0] hi, input logic [7:0] tc, input logic [7:0] e);
    wr(TC, 8'h08);
    wr(IC, 8'h00);
    wr(HB, hi);
    wr(LO, 8'hFC);
    wr(TC, tc);
    cyc(40);
    wr(TC, 8'h08);
    rdchk(HB, hi);
    wr(HB, 8'h77);
    rd(LO, v);
    rdchk(HB, e);
    rdchk(IC, {5'h00, 8'(hi == 8'hFF || tc[6]) == 8'h01, 2'h0});
  endtask : t_wide

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    rdchk(TC, TIMER_CTRL_RESET);
    rdchk(HB, 8'h00);
    chk("irq at reset", 8'(irq), 8'h00);
    t_pin();
    t_psc();
    t_run();
    t_ovf();
    t_wide(8'h34, 8'h88, 8'h35);
    t_wide(8'hFF, 8'h88, 8'h00);
    t_wide(8'h12, 8'hC8, 8'h12);
    give_verdict();
  end
endmodule : tcp_timer_counter_test
